// [rtl/pcc_pkg.sv]
package pcc_pkg;

  // --------------------------------------------------------------------
  // Clock source selection
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_SLOW  = 2'b00,
    SRC_MAIN  = 2'b01,
    SRC_PLL_A = 2'b10,
    SRC_PLL_B = 2'b11
  } pcc_src_e;

  // --------------------------------------------------------------------
  // Frequency measurement states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    FM_IDLE = 2'b00,
    FM_ARM  = 2'b01,
    FM_RUN  = 2'b10,
    FM_DONE = 2'b11
  } pcc_fm_e;

endpackage

// [rtl/pcc_regs.svh]
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PCC_OFF_SCER      8'h00
`define PCC_OFF_SCDR      8'h04
`define PCC_OFF_SCSR      8'h08
`define PCC_OFF_MOR       8'h0C
`define PCC_OFF_MCFR      8'h10
`define PCC_OFF_PLLA      8'h14
`define PCC_OFF_PLLB      8'h18
`define PCC_OFF_MCKR      8'h1C
`define PCC_OFF_ICPR      8'h20
`define PCC_OFF_IER       8'h24
`define PCC_OFF_IDR       8'h28
`define PCC_OFF_IMR       8'h2C
`define PCC_OFF_SR        8'h30
`define PCC_PCK_BASE_HI   4'h4

// ----------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------
`define PCC_MOR_MASK      32'h0000_FF01
`define PCC_PLLA_MASK     32'h27FF_FFFF
`define PCC_PLLB_MASK     32'h37FF_FFFF
`define PCC_MCKR_MASK     32'h0000_031F
`define PCC_PCK_MASK      32'h0000_001F
`define PCC_ICPR_MASK     32'h0001_0001
`define PCC_IRQ_MASK      32'h0000_0F0F
`define PCC_CFG_RST       32'h0000_0000
`define PCC_SCSR_RST      32'h0000_0001

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PCC_OSC_CNT_MSB   15
`define PCC_OSC_CNT_LSB   8
`define PCC_PLL_DIV_MSB   7
`define PCC_PLL_DIV_LSB   0
`define PCC_PLL_CNT_MSB   13
`define PCC_PLL_CNT_LSB   8
`define PCC_PLL_MUL_MSB   26
`define PCC_PLL_MUL_LSB   16
`define PCC_USB_DIV_MSB   29
`define PCC_USB_DIV_LSB   28
`define PCC_CSS_MSB       1
`define PCC_CSS_LSB       0
`define PCC_PRESCALE_SEL_MSB      4
`define PCC_PRESCALE_SEL_LSB      2
`define PCC_MASTER_CLK_DIV_MSB      9
`define PCC_MASTER_CLK_DIV_LSB      8
`define PCC_PCK_BIT_LSB   8

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define PCC_OSC_STARTUP_MULT 11'd8
`define PCC_FREQ_WINDOW      5'd16
`define PCC_SETTLE_EDGES     2'd2

`endif

// [rtl/pcc_top.sv]
// Local design decisions: register access over Avalon-MM and the register offsets.
`include "pcc_regs.svh"

module pcc_top #(
  parameter int unsigned FREQ_W = 16
) (
  // System
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  // Clock sources, asynchronous to i_clk_sys
  input  wire logic        i_slow_clk,
  input  wire logic        i_main_clk,
  input  wire logic        i_pll_a_clk,
  input  wire logic        i_pll_b_clk,
  // Avalon-MM slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Generated clocks
  output logic      [3:0]  o_prog_clk_out,
  output logic             o_master_clk,
  output logic             o_proc_clk,
  output logic             o_usb_clk,
  // Analog controls and interrupt
  output logic             o_main_osc_en,
  output logic             o_pll_a_on,
  output logic             o_pll_b_on,
  output logic             o_irq
);
  import pcc_pkg::*;

  // --------------------------------------------------------------------
  // Source synchronisers
  // --------------------------------------------------------------------
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic       main_osc_stable_q;
  logic [1:0] pll_on_q;

  // Two flops before use, third only for edge detection
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end else begin
      s1_q <= {i_pll_b_clk, i_pll_a_clk, i_main_clk, i_slow_clk};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Sources only count while their generator runs
  wire [3:0] src_on   = {pll_on_q, main_osc_stable_q, 1'b1};
  wire [3:0] src_lvl  = s2_q & src_on;
  wire [3:0] src_rise = s2_q & ~s3_q & src_on;
  wire       slow_tick = src_rise[SRC_SLOW];

  // --------------------------------------------------------------------
  // Avalon slave: one wait state, access taken when waitrequest is low
  // --------------------------------------------------------------------
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;

  wire        req   = i_avs_read | i_avs_write;
  wire        wr    = i_avs_write & ~wait_q;
  wire [31:0] wd    = i_avs_writedata;
  wire [31:0] bmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                       {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire [31:0] wdm   = wd & bmask;

  // Byte-lane merge of a write into a stored register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] msk);
    merge = ((old_v & ~bmask) | (wd & bmask)) & msk;
  endfunction

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Address decode
  wire       wr_scer = wr && (i_avs_address == `PCC_OFF_SCER);
  wire       wr_scdr = wr && (i_avs_address == `PCC_OFF_SCDR);
  wire       wr_mor  = wr && (i_avs_address == `PCC_OFF_MOR);
  wire       wr_plla = wr && (i_avs_address == `PCC_OFF_PLLA);
  wire       wr_pllb = wr && (i_avs_address == `PCC_OFF_PLLB);
  wire       wr_mckr = wr && (i_avs_address == `PCC_OFF_MCKR);
  wire       wr_icpr = wr && (i_avs_address == `PCC_OFF_ICPR);
  wire       wr_ier  = wr && (i_avs_address == `PCC_OFF_IER);
  wire       wr_idr  = wr && (i_avs_address == `PCC_OFF_IDR);
  wire       pck_hit = (i_avs_address[7:4] == `PCC_PCK_BASE_HI);
  wire [1:0] pck_idx = i_avs_address[3:2];

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  logic [31:0] mor_q;
  logic [31:0] pll_q [0:1];
  logic [31:0] mckr_q;
  logic [31:0] icpr_q;
  logic [31:0] imr_q;
  logic [31:0] pck_q [0:3];
  logic        proc_en_q;
  logic [3:0]  pck_en_q;

  wire [31:0] mor_new  = merge(mor_q, `PCC_MOR_MASK);
  wire [31:0] plla_new = merge(pll_q[0], `PCC_PLLA_MASK);
  wire [31:0] pllb_new = merge(pll_q[1], `PCC_PLLB_MASK);
  wire [3:0]  pck_wdm  = wdm[`PCC_PCK_BIT_LSB +: 4];

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      mor_q    <= `PCC_CFG_RST;
      pll_q[0] <= `PCC_CFG_RST;
      pll_q[1] <= `PCC_CFG_RST;
      mckr_q   <= `PCC_CFG_RST;
      icpr_q   <= `PCC_CFG_RST;
      imr_q    <= `PCC_CFG_RST;
    end else begin
      if (wr_mor)  mor_q    <= mor_new;
      if (wr_plla) pll_q[0] <= plla_new;
      if (wr_pllb) pll_q[1] <= pllb_new;
      if (wr_mckr) mckr_q   <= merge(mckr_q, `PCC_MCKR_MASK);
      if (wr_icpr) icpr_q   <= merge(icpr_q, `PCC_ICPR_MASK);
      if (wr_ier)  imr_q    <= imr_q | (wdm & `PCC_IRQ_MASK);
      if (wr_idr)  imr_q    <= imr_q & ~wdm;
    end
  end

  // Output clock configuration and write-one enable/disable
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int k = 0; k < 4; k++) pck_q[k] <= `PCC_CFG_RST;
      proc_en_q <= 1'(`PCC_SCSR_RST);
      pck_en_q  <= 4'h0;
    end else begin
      if (wr && pck_hit) pck_q[pck_idx] <= merge(pck_q[pck_idx],
                                                 `PCC_PCK_MASK);
      if (wr_scer) begin
        proc_en_q <= proc_en_q | wdm[0];
        pck_en_q  <= pck_en_q | pck_wdm;
      end else if (wr_scdr) begin
        proc_en_q <= proc_en_q & ~wdm[0];
        pck_en_q  <= pck_en_q & ~pck_wdm;
      end
    end
  end

  // --------------------------------------------------------------------
  // Main oscillator start-up
  // --------------------------------------------------------------------
  logic [10:0] osc_cnt_q;
  wire         osc_en   = mor_q[0];
  wire [10:0]  osc_load = 11'(mor_new[`PCC_OSC_CNT_MSB:`PCC_OSC_CNT_LSB])
                          * `PCC_OSC_STARTUP_MULT;

  // Reload on every write so a new count restarts the wait
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      osc_cnt_q <= 11'h000;
      main_osc_stable_q   <= 1'b0;
    end else if (wr_mor) begin
      osc_cnt_q <= osc_load;
      main_osc_stable_q   <= 1'b0;
    end else if (!osc_en) begin
      osc_cnt_q <= 11'h000;
      main_osc_stable_q   <= 1'b0;
    end else if (osc_cnt_q == 11'h000) begin
      main_osc_stable_q   <= 1'b1;
    end else if (slow_tick) begin
      osc_cnt_q <= osc_cnt_q - 11'h001;
    end
  end

  // --------------------------------------------------------------------
  // Main clock frequency measurement
  // --------------------------------------------------------------------
  pcc_fm_e           fm_q;
  logic [4:0]        fwin_q;
  logic [FREQ_W-1:0] fcnt_q;
  logic [FREQ_W-1:0] main_freq_count_q;
  logic              mrdy_q;

  // Window aligned to a slow edge; main edges above half of i_clk_sys
  // cannot be seen by this sampling scheme
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      fm_q    <= FM_IDLE;
      fwin_q  <= 5'h00;
      fcnt_q  <= '0;
      main_freq_count_q <= '0;
      mrdy_q  <= 1'b0;
    end else if (wr_mor || !main_osc_stable_q) begin
      fm_q   <= FM_IDLE;
      mrdy_q <= 1'b0;
    end else begin
      case (fm_q)
        FM_IDLE: begin
          fm_q <= FM_ARM;
        end
        FM_ARM: begin
          if (slow_tick) begin
            fm_q   <= FM_RUN;
            fwin_q <= 5'h00;
            fcnt_q <= '0;
          end
        end
        FM_RUN: begin
          if (src_rise[SRC_MAIN]) fcnt_q <= fcnt_q + 1'b1;
          if (slow_tick) begin
            fwin_q <= fwin_q + 5'h01;
            if (fwin_q == `PCC_FREQ_WINDOW - 5'h01) begin
              fm_q    <= FM_DONE;
              main_freq_count_q <= fcnt_q;
              mrdy_q  <= 1'b1;
            end
          end
        end
        FM_DONE: begin
          fm_q <= FM_DONE;
        end
        default: begin
          fm_q <= FM_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // PLL lock counters and enables
  // --------------------------------------------------------------------
  logic [1:0] lock_q;
  wire  [1:0] wr_pll = {wr_pllb, wr_plla};
  wire [31:0] pll_new [0:1];
  assign pll_new[0] = plla_new;
  assign pll_new[1] = pllb_new;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pll
      logic [5:0] cnt_q;
      logic       busy_q;
      wire        div_on = |pll_q[p][`PCC_PLL_DIV_MSB:`PCC_PLL_DIV_LSB];
      wire        mul_on = |pll_q[p][`PCC_PLL_MUL_MSB:`PCC_PLL_MUL_LSB];

      // Any write restarts the lock wait
      always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
          cnt_q     <= 6'h00;
          busy_q    <= 1'b0;
          lock_q[p] <= 1'b0;
          pll_on_q[p] <= 1'b0;
        end else begin
          pll_on_q[p] <= div_on & mul_on;
          if (wr_pll[p]) begin
            cnt_q     <= pll_new[p][`PCC_PLL_CNT_MSB:`PCC_PLL_CNT_LSB];
            busy_q    <= 1'b1;
            lock_q[p] <= 1'b0;
          end else if (busy_q && cnt_q == 6'h00) begin
            busy_q    <= 1'b0;
            lock_q[p] <= 1'b1;
          end else if (busy_q && slow_tick) begin
            cnt_q     <= cnt_q - 6'h01;
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Master source with fallback while the selected PLL relocks
  // --------------------------------------------------------------------
  logic [1:0] mcss_q;
  wire  [1:0] mcss_cfg = mckr_q[`PCC_CSS_MSB:`PCC_CSS_LSB];
  wire        fb_a     = (mcss_cfg == SRC_PLL_A) && !lock_q[0];
  wire        fb_b     = (mcss_cfg == SRC_PLL_B) && !lock_q[1];
  wire  [1:0] mcss_eff = fb_a ? SRC_SLOW :
                         fb_b ? SRC_MAIN : mcss_cfg;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      mcss_q <= SRC_SLOW;
    end else begin
      mcss_q <= mcss_eff;
    end
  end

  // --------------------------------------------------------------------
  // Prescaler entries: 0..3 output clocks, 4 processor clock
  // --------------------------------------------------------------------
  wire [1:0] ent_css  [0:4];
  wire [2:0] ent_prescale_sel [0:4];
  wire [4:0] ent_rst;
  wire [4:0] ent_gate;
  logic [4:0] out_q;
  logic [4:0] rdy_q;

  assign ent_css[4]  = mcss_eff;
  assign ent_prescale_sel[4] = mckr_q[`PCC_PRESCALE_SEL_MSB:`PCC_PRESCALE_SEL_LSB];
  assign ent_rst[4]  = wr_mckr || (mcss_eff != mcss_q);
  assign ent_gate[4] = 1'b1;

  genvar i;
  generate
    for (i = 0; i < 5; i++) begin : g_ent
      logic [5:0] pcnt_q;
      logic [1:0] settle_q;
      wire        s_rise = src_rise[ent_css[i]];
      wire        s_lvl  = src_lvl[ent_css[i]];
      wire        lvl    = (ent_prescale_sel[i] == 3'd0) ? s_lvl :
                           (ent_prescale_sel[i] >= 3'd6) ? pcnt_q[5] :
                           pcnt_q[ent_prescale_sel[i] - 3'd1];

      if (i < 4) begin : g_cfg
        assign ent_css[i]  = pck_q[i][`PCC_CSS_MSB:`PCC_CSS_LSB];
        assign ent_prescale_sel[i] = pck_q[i][`PCC_PRESCALE_SEL_MSB:`PCC_PRESCALE_SEL_LSB];
        assign ent_rst[i]  = (wr && pck_hit && pck_idx == i) ||
                             ((wr_scer || wr_scdr) && pck_wdm[i]);
        assign ent_gate[i] = pck_en_q[i];
      end

      // Divider counts source edges; no glitch guard on reprogramming
      always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
          pcnt_q <= 6'h00;
          out_q[i] <= 1'b0;
        end else begin
          if (s_rise) pcnt_q <= pcnt_q + 6'h01;
          out_q[i] <= lvl & ent_gate[i];
        end
      end

      // Ready once the new setting has seen settled source edges
      always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
          settle_q <= 2'h0;
          rdy_q[i] <= 1'b0;
        end else if (ent_rst[i]) begin
          settle_q <= 2'h0;
          rdy_q[i] <= 1'b0;
        end else if (s_rise && !rdy_q[i]) begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == `PCC_SETTLE_EDGES - 2'h1) rdy_q[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Master divider, USB divider and output flops
  // --------------------------------------------------------------------
  logic       pck_d1_q;
  logic [1:0] mcnt_q;
  logic [1:0] ucnt_q;
  wire  [1:0] master_clk_div   = mckr_q[`PCC_MASTER_CLK_DIV_MSB:`PCC_MASTER_CLK_DIV_LSB];
  wire  [1:0] usb_clk_div = pll_q[1][`PCC_USB_DIV_MSB:`PCC_USB_DIV_LSB];
  wire        p_rise = out_q[4] & ~pck_d1_q;
  wire        m_lvl  = (master_clk_div == 2'd0) ? out_q[4] :
                       (master_clk_div == 2'd1) ? mcnt_q[0] : mcnt_q[1];
  wire        u_lvl  = (usb_clk_div == 2'd0) ? src_lvl[SRC_PLL_B] :
                       (usb_clk_div == 2'd1) ? ucnt_q[0] : ucnt_q[1];

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pck_d1_q     <= 1'b0;
      mcnt_q       <= 2'h0;
      ucnt_q       <= 2'h0;
      o_master_clk <= 1'b0;
      o_proc_clk   <= 1'b0;
      o_usb_clk    <= 1'b0;
    end else begin
      pck_d1_q     <= out_q[4];
      if (p_rise) mcnt_q <= mcnt_q + 2'h1;
      if (src_rise[SRC_PLL_B]) ucnt_q <= ucnt_q + 2'h1;
      o_master_clk <= m_lvl;
      o_proc_clk   <= out_q[4] & proc_en_q;
      o_usb_clk    <= u_lvl;
    end
  end

  // --------------------------------------------------------------------
  // Status, interrupt and read-back
  // --------------------------------------------------------------------
  wire        master_clk_ready = rdy_q[4] & ~fb_a & ~fb_b;
  wire [3:0]  pckrdy = rdy_q[3:0] & pck_en_q;
  wire [31:0] sr_v   = {20'h00000, pckrdy, 4'h0, master_clk_ready, lock_q, main_osc_stable_q};
  wire [31:0] scsr_v = {20'h00000, pck_en_q, 7'h00, proc_en_q};
  wire [31:0] mcfr_v = {15'h0000, mrdy_q, 16'(main_freq_count_q)};

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq         <= 1'b0;
      o_main_osc_en <= 1'b0;
      o_pll_a_on    <= 1'b0;
      o_pll_b_on    <= 1'b0;
    end else begin
      o_irq         <= |(sr_v & imr_q);
      o_main_osc_en <= osc_en;
      o_pll_a_on    <= pll_on_q[0];
      o_pll_b_on    <= pll_on_q[1];
    end
  end

  // Unmapped addresses read zero
  assign rd_mux =
    (i_avs_address == `PCC_OFF_SCSR) ? scsr_v :
    (i_avs_address == `PCC_OFF_MOR)  ? mor_q :
    (i_avs_address == `PCC_OFF_MCFR) ? mcfr_v :
    (i_avs_address == `PCC_OFF_PLLA) ? pll_q[0] :
    (i_avs_address == `PCC_OFF_PLLB) ? pll_q[1] :
    (i_avs_address == `PCC_OFF_MCKR) ? mckr_q :
    (i_avs_address == `PCC_OFF_ICPR) ? icpr_q :
    (i_avs_address == `PCC_OFF_IMR)  ? imr_q :
    (i_avs_address == `PCC_OFF_SR)   ? sr_v :
    pck_hit                          ? pck_q[pck_idx] : 32'h0000_0000;

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_prog_clk_out    = out_q[3:0];

endmodule

// [verification/pcc_checker.sv]
// --------------------------------------------------------------------
// Port-level checks of the clock controller
// --------------------------------------------------------------------
module pcc_checker (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_rstn,
  // Register bus
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // Clock outputs and analog controls
  input wire logic [3:0]  o_prog_clk_out,
  input wire logic        o_main_osc_en,
  input wire logic        o_pll_a_on,
  input wire logic        o_pll_b_on
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // Full-word write taking effect at this edge
  wire logic       wr_ok;
  wire logic [7:0] wa;
  assign wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable == 4'hF;
  assign wa    = i_avs_address;

  a_wait_answer: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no bus answer");
  a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest &&
    wa == 8'h80 |-> o_avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_osc_enable_on: assert property (
    wr_ok && wa == 8'h0C && i_avs_writedata[0] |-> ##[1:3] o_main_osc_en)
    else $error("oscillator enable not driven");
  a_pll_a_run: assert property (wr_ok && wa == 8'h14 &&
    i_avs_writedata[7:0] != 8'h00 && i_avs_writedata[26:16] != 11'h000
    |-> ##[1:3] o_pll_a_on) else $error("pll a not on");
  a_pll_a_div_off: assert property (wr_ok && wa == 8'h14 &&
    i_avs_writedata[7:0] == 8'h00 |-> ##[1:3] !o_pll_a_on)
    else $error("pll a on with divider off");
  a_pll_b_mul_off: assert property (wr_ok && wa == 8'h18 &&
    i_avs_writedata[26:16] == 11'h000 |-> ##[1:3] !o_pll_b_on)
    else $error("pll b on with multiplier off");
  a_out_disable_low: assert property (wr_ok && wa == 8'h04 &&
    i_avs_writedata[8] |-> ##6 !o_prog_clk_out[0])
    else $error("disabled output still toggling");
endmodule

bind pcc_top pcc_checker pcc_checker_inst (.*);

// [verification/pll_master_and_output_clock_ctrl_tb_top.sv]
module pll_master_and_output_clock_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } pcc_row_s;
  // ------------------------------------------------------------------
  // Ports, counters and ordinary cases: write, read back, expect
  // ------------------------------------------------------------------
  logic        i_clk_sys = 1'b0, i_rstn = 1'b0, i_slow_clk = 1'b0;
  logic        i_main_clk = 1'b0, i_pll_a_clk = 1'b0, i_pll_b_clk = 1'b0;
  logic [7:0]  i_avs_address = 8'h00;
  logic        i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic [3:0]  i_avs_byteenable = 4'hF;
  logic [31:0] o_avs_readdata, rd, p;
  logic [3:0]  o_prog_clk_out;
  logic        o_avs_waitrequest, o_master_clk, o_proc_clk, o_usb_clk;
  logic        o_main_osc_en, o_pll_a_on, o_pll_b_on, o_irq;
  int          fails = 0, checks_done = 0, cyc = 0;
  pcc_row_s    rows [6] = '{'{8'h4C, 32'hFFFF_FFFF, 32'h0000_001F},
    '{8'h1C, 32'hFFFF_FFFF, 32'h0000_031F},
    '{8'h80, 32'h1234_5678, 32'h0000_0000},
    '{8'h08, 32'hFFFF_FFFF, 32'h0000_0001},
    '{8'h18, 32'h0004_0805, 32'h0004_0805},
    '{8'h18, 32'h0000_0805, 32'h0000_0805}};

  pcc_top pcc_top_inst (.*);

  always #12.5 i_clk_sys = ~i_clk_sys;
  // Sources well under half the system rate so sampling keeps every edge
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 7) i_slow_clk <= ~i_slow_clk;
    if (cyc % 3 == 2) i_main_clk <= ~i_main_clk;
    if (cyc % 2 == 1) i_pll_a_clk <= ~i_pll_a_clk;
    if (cyc % 5 == 4) i_pll_b_clk <= ~i_pll_b_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is sampled low, then released;
  // no local limit, a hung slave is left to the watchdog
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk_sys);
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_write     <= w;
    i_avs_read      <= !w;
    do begin
      @(posedge i_clk_sys);
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  // Read until one bit shows v or the try count runs out
  task automatic poll(input logic [7:0] a, input int b, input logic v,
                      input int lim);
    for (int n = 0; n < lim; n++) begin
      bus(1'b0, a, 32'h0000_0000);
      if (rd[b] === v) break;
    end
    chk((rd >> b) & 32'h0000_0001, {31'h0000_0000, v});
  endtask

  // System cycles between two rising edges of a clock output:
  // 0 output clock 0, 1 master, 2 processor, 3 USB
  task automatic period(input logic [1:0] sel, output logic [31:0] n);
    logic prev;
    logic cur;
    int   e;
    prev = 1'b1;
    e = 0;
    n = 32'h0000_0000;
    for (int k = 0; k < 400 && e < 2; k++) begin
      @(posedge i_clk_sys);
      cur = (sel == 2'd0) ? o_prog_clk_out[0] :
            (sel == 2'd1) ? o_master_clk :
            (sel == 2'd2) ? o_proc_clk : o_usb_clk;
      if (cur === 1'b1 && prev === 1'b0) e++;
      if (e == 1) n++;
      prev = cur;
    end
  endtask

  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog far beyond the fewer than 2000 cycles the run needs
  initial begin
    repeat (8000) @(posedge i_clk_sys);
    fails++;
    final_report();
  end

  // Row loop, then mid-run reset and the timed sequences
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    @(posedge i_clk_sys);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    rdc(8'h14, 32'h0000_0000);
    rdc(8'h1C, 32'h0000_0000);
    rdc(8'h08, 32'h0000_0001);
    // Main clock is gated until the oscillator is stable: use slow first
    bus(1'b1, 8'h40, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0100);
    rdc(8'h08, 32'h0000_0101);
    poll(8'h30, 8, 1'b1, 50);
    period(2'd0, p);
    chk(p, 32'd16);
    bus(1'b1, 8'h04, 32'h0000_0100);
    rdc(8'h08, 32'h0000_0001);
    bus(1'b1, 8'h40, 32'h0000_0004);
    bus(1'b1, 8'h00, 32'h0000_0100);
    poll(8'h30, 8, 1'b1, 50);
    period(2'd0, p);
    chk(p, 32'd32);
    bus(1'b1, 8'h0C, 32'h0000_0101);
    poll(8'h30, 0, 1'b0, 1);
    repeat (90) @(posedge i_clk_sys);
    poll(8'h30, 0, 1'b0, 1);
    poll(8'h30, 0, 1'b1, 100);
    poll(8'h10, 16, 1'b1, 200);
    chk(32'(rd[15:0] >= 16'd42 && rd[15:0] <= 16'd43), 32'd1);
    bus(1'b1, 8'h04, 32'h0000_0100);
    bus(1'b1, 8'h40, 32'h0000_0001);
    bus(1'b1, 8'h00, 32'h0000_0100);
    poll(8'h30, 8, 1'b1, 50);
    period(2'd0, p);
    chk(p, 32'd6);
    bus(1'b1, 8'h20, 32'h0000_0001);
    bus(1'b1, 8'h24, 32'h0000_0002);
    bus(1'b1, 8'h14, 32'h2003_0605);
    poll(8'h30, 1, 1'b0, 1);
    repeat (60) @(posedge i_clk_sys);
    poll(8'h30, 1, 1'b0, 1);
    poll(8'h30, 1, 1'b1, 60);
    chk(32'({o_pll_a_on, o_irq}), 32'h0000_0003);
    bus(1'b1, 8'h14, 32'h2003_0600);
    repeat (3) @(posedge i_clk_sys);
    chk(32'(o_pll_a_on), 32'h0000_0000);
    bus(1'b1, 8'h18, 32'h1004_0805);
    poll(8'h30, 2, 1'b0, 1);
    poll(8'h30, 2, 1'b1, 60);
    period(2'd3, p);
    chk(p, 32'd20);
    bus(1'b1, 8'h1C, 32'h0000_0001);
    poll(8'h30, 3, 1'b0, 1);
    poll(8'h30, 3, 1'b1, 50);
    period(2'd1, p);
    chk(p, 32'd6);
    bus(1'b1, 8'h1C, 32'h0000_0005);
    poll(8'h30, 3, 1'b1, 50);
    period(2'd1, p);
    chk(p, 32'd12);
    period(2'd2, p);
    chk(p, 32'd12);
    bus(1'b1, 8'h1C, 32'h0000_0105);
    poll(8'h30, 3, 1'b1, 50);
    period(2'd1, p);
    chk(p, 32'd24);
    bus(1'b1, 8'h04, 32'h0000_0001);
    rdc(8'h08, 32'h0000_0100);
    period(2'd2, p);
    chk(p, 32'd0);
    final_report();
  end
endmodule
